// ===== common/sgs_defs.vh
// Constants for the servo gain switch selection block
`ifndef SGS_DEFS_VH
`define SGS_DEFS_VH
// Register byte offsets
`define SGS_OFF_CTRL 8'h00
`define SGS_OFF_SPD_SEL 8'h04
`define SGS_OFF_SPD_DLY 8'h08
`define SGS_OFF_SPD_LVL 8'h0C
`define SGS_OFF_SPD_HYS 8'h10
`define SGS_OFF_TRQ_SEL 8'h14
`define SGS_OFF_TRQ_DLY 8'h18
`define SGS_OFF_TRQ_LVL 8'h1C
`define SGS_OFF_TRQ_HYS 8'h20
`define SGS_OFF_POS_SEL 8'h24
`define SGS_OFF_POS_DLY 8'h28
`define SGS_OFF_POS_LVL 8'h2C
`define SGS_OFF_POS_HYS 8'h30
`define SGS_OFF_INP_RNG 8'h34
`define SGS_OFF_RAMP 8'h38
`define SGS_OFF_STATUS 8'h3C
// Register indices of set bases and of the single registers
`define SGS_IDX_SPD 4'h1
`define SGS_IDX_TRQ 4'h5
`define SGS_IDX_POS 4'h9
`define SGS_IDX_INP 4'hD
`define SGS_IDX_RAMP 4'hE
`define SGS_IDX_STATUS 4'hF
// Field positions
`define SGS_CTRL_MODE_MSB 1
`define SGS_CTRL_MODE_LSB 0
`define SGS_SEL_MSB 3
`define SGS_ST_GAIN2 0
`define SGS_ST_POSGAIN2 1
`define SGS_ST_PEND 2
// Reset value of every setting register
`define SGS_RST_CFG 16'h0000
// Control modes
`define SGS_CM_POS 2'h0
`define SGS_CM_SPD 2'h1
`define SGS_CM_TRQ 2'h2
// Selector codes
`define SGS_SEL_GAIN1 4'h0
`define SGS_SEL_GAIN2 4'h1
`define SGS_SEL_NET 4'h2
`define SGS_SEL_TRQCHG 4'h3
`define SGS_SEL_SPDCHG 4'h4
`define SGS_SEL_SPDCMD 4'h5
`define SGS_SEL_POSERR 4'h6
`define SGS_SEL_CMDRX 4'h7
`define SGS_SEL_INPOS 4'h8
`define SGS_SEL_MOTSPD 4'h9
`define SGS_SEL_COMBO 4'hA
// Highest selector value per control mode
`define SGS_SPD_SEL_MAX 4'h5
`define SGS_TRQ_SEL_MAX 4'h3
`define SGS_POS_SEL_MAX 4'hA
// Timing
`define SGS_CLK_NS 50
`define SGS_CTL_NS 166000
`define SGS_TENTH_NS 100000
`define SGS_SEC_NS 1000000000
`define SGS_CTL_CYC (`SGS_CTL_NS / `SGS_CLK_NS)
`define SGS_TENTH_CYC (`SGS_TENTH_NS / `SGS_CLK_NS)
// Speed change per control cycle to units of 10 r/min per second
`define SGS_SPD_RATE_MUL (`SGS_SEC_NS / `SGS_CTL_NS / 10)
`endif

// ===== core/sgs_gain_switch.v
// Gain set selection for the servo control loop, with APB settings
//
// Notes on behaviour
// R01 - Selector 0/1 fix gain set one or two
// R02 - Selector 2 follows network gain select bit
// R03 - Network select changes gain set without delay
// R04 - Selector 3 uses torque command change level
// R05 - Selector 4 uses speed command change rate
// R06 - Selector 5 uses speed command magnitude
// R07 - Delay applies only on return to set one
// R08 - Torque mode accepts selector values 0 to 3
// R09 - Position gain follows its own ramp time
// R10 - Torque change evaluated each 166 us cycle
// R11 - Fluctuating condition cancels the pending switch
// R12 - Mode 6 compares accumulated position error
// R13 - Mode 7 switches on received position command
// R14 - Mode 8 switches outside in-position range
// R15 - Mode 10 combines command receipt and speed
// R16 - Return delay counted in 0.1 ms units
// R17 - Enter above level+hyst, return below level-hyst
// R18 - Renewed condition restarts return delay countdown
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "sgs_defs.vh"

module sgs_gain_switch (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Control loop samples
   input wire signed [15:0] torqueCmd,
   input wire signed [15:0] speedCmd,
   input wire signed [15:0] motorSpeed,
   input wire signed [31:0] posError,
   input wire [15:0] posCmdDelta,
   input wire netGainSel,
   // Gain selections and control tick
   output wire gainSet2,
   output wire posGainSet2,
   output wire ctlTick
);

   // Magnitude of a difference of two signed values
   function [31:0] absDiff;
      input signed [32:0] a;
      input signed [32:0] b;
      reg signed [32:0] d;
      reg signed [32:0] nd;
      begin
         d = a - b;
         nd = -d;
         // Both operands fit in 32 signed bits, so the magnitude fits in 32 bits
         absDiff = d[32] ? nd[31:0] : d[31:0];
      end
   endfunction

   // Settings words indexed by register number; the status word has no storage
   reg [15:0] cfg_r [0:14];
   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;
   reg gain2_r;
   reg posGain2_r;
   reg tick_r;
   reg pend_r;
   reg [11:0] ctlCnt_r;
   reg [10:0] tenth_r;
   reg [15:0] dlyCnt_r;
   reg [15:0] rampCnt_r;
   reg signed [15:0] tqPrev_r;
   reg signed [15:0] spPrev_r;
   integer i;

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign gainSet2 = gain2_r;
   assign posGainSet2 = posGain2_r;
   assign ctlTick = tick_r;

   // Active settings picked by control mode
   wire [1:0] cmode = cfg_r[0][`SGS_CTRL_MODE_MSB:`SGS_CTRL_MODE_LSB];
   reg [3:0] base;
   reg [3:0] selMax;
   always @* begin
      case (cmode)
         `SGS_CM_SPD: begin
            base = `SGS_IDX_SPD;
            selMax = `SGS_SPD_SEL_MAX;
         end
         `SGS_CM_TRQ: begin
            base = `SGS_IDX_TRQ;
            selMax = `SGS_TRQ_SEL_MAX; // R08
         end
         default: begin
            base = `SGS_IDX_POS;
            selMax = `SGS_POS_SEL_MAX;
         end
      endcase
   end
   wire [3:0] sel = cfg_r[base][`SGS_SEL_MSB:0];
   wire [15:0] dly = cfg_r[base + 4'h1];
   wire [15:0] lvl = cfg_r[base + 4'h2];
   wire [15:0] hys = cfg_r[base + 4'h3];
   wire selOk = sel <= selMax;

   // Sign-extended samples so that differences cannot wrap
   wire signed [32:0] tqExt = {{17{torqueCmd[15]}}, torqueCmd};
   wire signed [32:0] tqPrevExt = {{17{tqPrev_r[15]}}, tqPrev_r};
   wire signed [32:0] spExt = {{17{speedCmd[15]}}, speedCmd};
   wire signed [32:0] spPrevExt = {{17{spPrev_r[15]}}, spPrev_r};
   wire signed [32:0] motExt = {{17{motorSpeed[15]}}, motorSpeed};
   wire signed [32:0] errExt = {posError[31], posError};
   wire signed [32:0] zeroExt = 33'h0_0000_0000;

   // Changes measured over one control cycle and present magnitudes
   wire [31:0] tqDelta = absDiff(tqExt, tqPrevExt); // R10
   wire [31:0] spDelta = absDiff(spExt, spPrevExt);
   // A 16-bit delta times the rate factor always fits in the low word
   wire [63:0] spdProd = spDelta * `SGS_SPD_RATE_MUL;
   wire [31:0] spdRate = spdProd[31:0]; // R05
   wire [31:0] spdCmdMag = absDiff(spExt, zeroExt); // R06
   wire [31:0] motMag = absDiff(motExt, zeroExt);
   wire [31:0] errMag = absDiff(errExt, zeroExt); // R12
   wire cmdRx = posCmdDelta != 16'h0000; // R13

   // Upper threshold keeps its carry; lower one is only valid while lvl >= hys
   wire [16:0] lvlSum = {1'b0, lvl} + {1'b0, hys};
   wire [31:0] hiLvl = {15'h0000, lvlSum};
   wire [31:0] loLvl = {16'h0000, lvl - hys};
   wire loOk = lvl >= hys;

   // Fixed selections that act at once, without tick or delay
   reg fixed;
   reg fixedVal;
   always @* begin
      fixed = 1'b1;
      fixedVal = 1'b0;
      if (!selOk) begin
         fixedVal = 1'b0;
      end else begin
         case (sel)
            `SGS_SEL_GAIN1: fixedVal = 1'b0; // R01
            `SGS_SEL_GAIN2: fixedVal = 1'b1; // R01
            `SGS_SEL_NET: fixedVal = netGainSel; // R02 R03
            `SGS_SEL_SPDCHG: begin
               // Position mode treats this value as gain set one
               fixedVal = 1'b0;
               fixed = cmode != `SGS_CM_SPD;
            end
            default: fixed = 1'b0;
         endcase
      end
   end

   // Enter and return conditions of the evaluated selectors
   reg [31:0] mag;
   reg enter;
   reg rel;
   always @* begin
      case (sel)
         `SGS_SEL_TRQCHG: mag = tqDelta; // R04
         `SGS_SEL_SPDCHG: mag = spdRate; // R05
         `SGS_SEL_SPDCMD: mag = spdCmdMag; // R06
         `SGS_SEL_POSERR: mag = errMag; // R12
         default: mag = motMag;
      endcase
      case (sel)
         `SGS_SEL_CMDRX: begin
            enter = cmdRx; // R13
            rel = !cmdRx;
         end
         `SGS_SEL_INPOS: begin
            enter = errMag > {16'h0000, cfg_r[`SGS_IDX_INP]}; // R14
            rel = !enter;
         end
         `SGS_SEL_COMBO: begin
            enter = cmdRx; // R15
            rel = !cmdRx && loOk && (motMag <= loLvl); // R15
         end
         default: begin
            enter = mag > hiLvl; // R17
            rel = loOk && (mag < loLvl); // R17
         end
      endcase
   end

   // Counter end points compared at full integer width, so no constant is cut
   wire ctlPre = {20'h0_0000, ctlCnt_r} == `SGS_CTL_CYC - 2;
   wire ctlWrap = {20'h0_0000, ctlCnt_r} == `SGS_CTL_CYC - 1;
   wire tenthWrap = {21'h00_0000, tenth_r} == `SGS_TENTH_CYC - 1;

   // Control cycle tick and per-cycle sample history
   // The tick is registered so that all evaluated modes see one common edge
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctlCnt_r <= 12'h000;
         tick_r <= 1'b0;
         tqPrev_r <= 16'sh0000;
         spPrev_r <= 16'sh0000;
      end else begin
         tick_r <= ctlPre;
         if (ctlWrap) begin
            ctlCnt_r <= 12'h000;
         end else begin
            ctlCnt_r <= ctlCnt_r + 12'h001;
         end
         if (tick_r) begin
            tqPrev_r <= torqueCmd; // R10
            spPrev_r <= speedCmd;
         end
      end
   end

   // Gain set state with delayed return to set one
   // Entry is never delayed; a pending return is dropped at any tick that
   // shows the condition again or shows neither enter nor release
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gain2_r <= 1'b0;
         pend_r <= 1'b0;
         tenth_r <= 11'h000;
         dlyCnt_r <= 16'h0000;
      end else if (fixed) begin
         gain2_r <= fixedVal; // R01 R03
         pend_r <= 1'b0;
      end else begin
         if (tick_r) begin
            if (enter) begin
               gain2_r <= 1'b1; // R07
               pend_r <= 1'b0; // R18
            end else if (gain2_r && rel) begin
               if (!pend_r) begin
                  pend_r <= 1'b1;
                  tenth_r <= 11'h000;
                  dlyCnt_r <= 16'h0000;
               end
            end else begin
               pend_r <= 1'b0; // R11
            end
         end
         if (pend_r && !(tick_r && (enter || !rel))) begin
            if (dlyCnt_r >= dly) begin
               gain2_r <= 1'b0; // R07
               pend_r <= 1'b0;
            end else if (tenthWrap) begin
               tenth_r <= 11'h000;
               dlyCnt_r <= dlyCnt_r + 16'h0001; // R16
            end else begin
               tenth_r <= tenth_r + 11'h001;
            end
         end
      end
   end

   // Position loop gain rises after the ramp time and falls at once
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         posGain2_r <= 1'b0;
         rampCnt_r <= 16'h0000;
      end else if (!gain2_r) begin
         posGain2_r <= 1'b0; // R09
         rampCnt_r <= 16'h0000;
      end else if (!posGain2_r && tick_r) begin
         if (rampCnt_r >= cfg_r[`SGS_IDX_RAMP]) begin
            posGain2_r <= 1'b1; // R09
         end else begin
            rampCnt_r <= rampCnt_r + 16'h0001;
         end
      end
   end

   // APB decode
   wire setup = psel && !penable;
   wire [3:0] idx = paddr[5:2];
   wire badAddr = (paddr[7:6] != 2'b00) || (paddr[1:0] != 2'b00);
   reg wrBad;
   always @* begin
      case (idx)
         `SGS_IDX_STATUS: wrBad = 1'b1;
         `SGS_IDX_SPD: wrBad = pwdata[15:0] > {12'h000, `SGS_SPD_SEL_MAX};
         `SGS_IDX_TRQ: wrBad = pwdata[15:0] > {12'h000, `SGS_TRQ_SEL_MAX}; // R08
         `SGS_IDX_POS: wrBad = pwdata[15:0] > {12'h000, `SGS_POS_SEL_MAX};
         default: wrBad = 1'b0;
      endcase
   end
   wire [31:0] status = {29'h0000_0000, pend_r, posGain2_r, gain2_r};
   wire [31:0] rdVal = (idx == `SGS_IDX_STATUS) ? status : {16'h0000, cfg_r[idx]};

   // APB answer one cycle after setup; write lands on the access edge
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         for (i = 0; i < 15; i = i + 1) begin
            cfg_r[i] <= `SGS_RST_CFG;
         end
      end else begin
         pready_r <= setup;
         // Error flag stands with pready only and clears after the access
         if (setup) begin
            pslverr_r <= badAddr || (pwrite && wrBad);
            prdata_r <= (badAddr || pwrite) ? 32'h0000_0000 : rdVal;
         end else begin
            pslverr_r <= 1'b0;
         end
         if (psel && penable && pready_r && pwrite && !pslverr_r) begin
            cfg_r[idx] <= pwdata[15:0];
         end
      end
   end

endmodule

// ===== test/sgs_net_ctrl.sv
// Network controller model driving the gain select bit
`timescale 1ns/1ps
module sgs_net_ctrl (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Request from the bench
   input wire reqSel,
   input wire [3:0] lag,
   // Gain select bit
   output logic netGainSel
);
   logic [3:0] waitCnt_r;
   // Follow the requested level after lag cycles
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         netGainSel <= 1'b0;
         waitCnt_r <= 4'h0;
      end else if (reqSel == netGainSel) begin
         waitCnt_r <= 4'h0;
      end else if (waitCnt_r >= lag) begin
         netGainSel <= reqSel;
      end else begin
         waitCnt_r <= waitCnt_r + 4'h1;
      end
   end
endmodule

// ===== test/sgs_gain_switch_sva.sv
// Port assertions for the gain switch selection block
`timescale 1ns/1ps
module sgs_gain_switch_sva (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Gain outputs and control tick
   input wire gainSet2,
   input wire posGainSet2,
   input wire ctlTick
);
   logic [11:0] tickCnt_r;
   logic tickSeen_r;
   // Clocks since the last control tick
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_r <= 12'h000;
         tickSeen_r <= 1'b0;
      end else begin
         tickCnt_r <= ctlTick ? 12'h000 : tickCnt_r + 12'h001;
         tickSeen_r <= tickSeen_r | ctlTick;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ready_one_a: assert property (pready |=> !pready) else $error("pready too long");
   ready_setup_a: assert property (psel && !penable |=> pready) else $error("no pready");
   err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
   err_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000) else $error("err data");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper");
   bad_addr_a: assert property (psel && !penable && (paddr[1:0] != 2'b00 || paddr >= 8'h40
      || (pwrite && paddr == 8'h3C)) |=> pslverr) else $error("bad access accepted");
   tick_period_a: assert property (ctlTick && tickSeen_r |-> tickCnt_r == 12'hCF7)
      else $error("control tick period");
   tick_pulse_a: assert property (ctlTick |=> !ctlTick) else $error("tick width");
   pos_fall_a: assert property ($fell(gainSet2) |=> !posGainSet2)
      else $error("position gain held");
   pos_rise_a: assert property ($rose(posGainSet2) |-> $past(gainSet2))
      else $error("position gain early");
   pos_lag_a: assert property ($rose(gainSet2) |=> !posGainSet2)
      else $error("position gain with others");
endmodule
bind sgs_gain_switch sgs_gain_switch_sva chk (.mclk, .rst_n, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .gainSet2, .posGainSet2, .ctlTick);

// ===== test/sgs_gain_switch_tb.sv
// Self-checking bench for the gain switch selection block
`timescale 1ns/1ps
`include "sgs_defs.vh"
module sgs_gain_switch_tb;
   logic mclk, rst_n, psel, penable, pwrite, reqSel, pready, pslverr;
   logic netGainSel, gainSet2, posGainSet2, ctlTick;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [15:0] torqueCmd, speedCmd, base;
   logic [3:0] lag;
   logic [15:0] posCmd;
   integer errTotal = 0, checked = 0, seed = 36, i, n;
   logic [7:0] badA [5] = '{8'h3C, 8'h40, 8'h06, 8'h04, 8'h14};
   logic [31:0] badD [5] = '{32'h1, 32'h0, 32'h0, 32'h6, 32'h4};
   sgs_gain_switch dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .torqueCmd, .speedCmd, .motorSpeed(16'sh0), .posError(32'sh0),
      .posCmdDelta(posCmd), .netGainSel, .gainSet2, .posGainSet2, .ctlTick);
   sgs_net_ctrl peer (.mclk, .rst_n, .reqSel, .lag, .netGainSel);
   // Clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask
   task automatic waitTick;
      int k;
      k = 0;
      @(negedge mclk);
      while (ctlTick !== 1'b1 && k < 4000) begin
         k++;
         @(negedge mclk);
      end
      @(posedge mclk);
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
      checked++;
      if (g !== e) begin
         errTotal++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkG(input logic e);
      chk(32'(e), 32'(gainSet2), "gainSet2");
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      int k;
      logic err;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      @(negedge mclk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(negedge mclk);
      end
      if (k >= 20) errTotal++;
      rd = prdata;
      err = pslverr;
      @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(e), 32'(err), "pslverr");
   endtask
   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (90000) @(posedge mclk);
      errTotal++;
      completeRun;
   end
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, reqSel, paddr, pwdata, torqueCmd, speedCmd, lag} = 81'h0;
      posCmd = 16'h0000;
      cyc(10);
      rst_n <= 1'b1;
      for (i = 0; i < 16; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0, 1'b0);
         chk(32'h0, rd, "reset value");
      end
      for (i = 0; i < 5; i++) begin
         apb(1'b1, badA[i], badD[i], 1'b1);
      end
      apb(1'b0, `SGS_OFF_SPD_SEL, 32'h0, 1'b0);
      chk(32'h0, rd, "refused selector");
      apb(1'b1, `SGS_OFF_TRQ_SEL, 32'h3, 1'b0);
      apb(1'b0, `SGS_OFF_TRQ_SEL, 32'h0, 1'b0);
      chk(32'h3, rd, "torque selector");
      $display("test registers done");
      apb(1'b1, `SGS_OFF_CTRL, 32'(`SGS_CM_SPD), 1'b0);
      apb(1'b1, `SGS_OFF_SPD_DLY, 32'h2, 1'b0);
      apb(1'b1, `SGS_OFF_SPD_LVL, 32'h64, 1'b0);
      apb(1'b1, `SGS_OFF_SPD_HYS, 32'h14, 1'b0);
      apb(1'b1, `SGS_OFF_SPD_SEL, 32'h1, 1'b0);
      cyc(2);
      chkG(1'b1);
      apb(1'b1, `SGS_OFF_SPD_SEL, 32'h0, 1'b0);
      cyc(2);
      chkG(1'b0);
      apb(1'b1, `SGS_OFF_SPD_SEL, 32'h2, 1'b0);
      for (i = 0; i < 8; i++) begin
         reqSel <= 1'($random(seed));
         lag <= 4'($random(seed));
         @(posedge mclk);
         for (n = 0; n < 20 && netGainSel !== reqSel; n++) @(posedge mclk);
         cyc(2);
         chkG(reqSel);
      end
      $display("test fixed and network done");
      apb(1'b1, `SGS_OFF_SPD_SEL, 32'h5, 1'b0);
      speedCmd <= 16'sd130;
      waitTick;
      cyc(2);
      chkG(1'b1);
      speedCmd <= 16'sd100;
      waitTick;
      cyc(2);
      chkG(1'b1);
      chk(32'h1, 32'(posGainSet2), "posGainSet2");
      apb(1'b0, `SGS_OFF_STATUS, 32'h0, 1'b0);
      chk(32'h3, rd, "status");
      speedCmd <= -16'sd50;
      waitTick;
      speedCmd <= 16'sd130;
      waitTick;
      cyc(1000);
      chkG(1'b1);
      apb(1'b1, `SGS_OFF_SPD_DLY, 32'h1, 1'b0);
      speedCmd <= 16'sd50;
      waitTick;
      cyc(1900);
      chkG(1'b1);
      cyc(200);
      chkG(1'b0);
      $display("test speed level done");
      base = 16'($random(seed) % 1000);
      torqueCmd <= base;
      apb(1'b1, `SGS_OFF_TRQ_LVL, 32'hA, 1'b0);
      apb(1'b1, `SGS_OFF_TRQ_HYS, 32'h2, 1'b0);
      apb(1'b1, `SGS_OFF_CTRL, 32'(`SGS_CM_TRQ), 1'b0);
      waitTick;
      waitTick;
      cyc(2);
      chkG(1'b0);
      apb(1'b1, `SGS_OFF_TRQ_DLY, 32'h2, 1'b0);
      torqueCmd <= base + 16'sd20;
      waitTick;
      cyc(2);
      chkG(1'b1);
      waitTick;
      torqueCmd <= base + 16'sd30;
      waitTick;
      cyc(1000);
      chkG(1'b1);
      apb(1'b1, `SGS_OFF_TRQ_DLY, 32'h0, 1'b0);
      waitTick;
      cyc(2);
      chkG(1'b0);
      $display("test torque change done");
      apb(1'b1, `SGS_OFF_POS_SEL, 32'h7, 1'b0);
      apb(1'b1, `SGS_OFF_CTRL, 32'(`SGS_CM_POS), 1'b0);
      posCmd <= 16'($random(seed)) | 16'h0001;
      waitTick;
      cyc(2);
      chkG(1'b1);
      posCmd <= 16'h0000;
      waitTick;
      cyc(2);
      chkG(1'b0);
      $display("test command receipt done");
      completeRun;
   end
endmodule
